/* File: hdl/scs_pkg.sv */
package scs_pkg;

  // Word bits are numbered 0 = MSB on the channel side; positions here are LSB indices
  localparam int POS_NOTOP  = 15;
  localparam int POS_USP    = 14;
  localparam int POS_PCI    = 13;
  localparam int POS_PCHK   = 12;
  localparam int POS_INCLEN = 9;
  localparam int POS_BUSY   = 8;
  localparam int POS_UOP    = 7;

  // Unit status byte, low half of the unit address-status word
  localparam int US_SM   = 6;
  localparam int US_CUE  = 5;
  localparam int US_BUSY = 4;
  localparam int US_CE   = 3;
  localparam int US_DE   = 2;
  localparam int US_UC   = 1;
  localparam int US_UE   = 0;

  // io_control_command modifier field
  localparam int MOD_SEL_HI  = 2;
  localparam int MOD_SEL_LO  = 1;
  localparam int MOD_RST     = 0;
  localparam int MOD_ADDR_HI = 15;
  localparam int MOD_ADDR_LO = 8;

  localparam logic [1:0] SEL_CHAN  = 2'h0;
  localparam logic [1:0] SEL_UNIT  = 2'h1;
  localparam logic [1:0] SEL_CPTR  = 2'h2;
  localparam logic [1:0] SEL_RESID = 2'h3;

  // Function codes of the io_control_command
  localparam logic [2:0] FN_CTRL   = 3'h3;
  localparam logic [2:0] FN_ABORT  = 3'h4;
  localparam logic [2:0] FN_LAUNCH = 3'h5;
  localparam logic [2:0] FN_READ   = 3'h7;

  localparam logic [15:0] CPTR_STEP  = 16'h0003;
  localparam logic [15:0] CHAIN_SKIP = 16'h0006;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RESID_BIAS = 16'h0002;
  localparam logic [15:0] RESID_INC  = 16'h0001;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SELECT = 4'h2,
    ST_ACTIVE = 4'h4,
    ST_FETCH  = 4'h8
  } scs_state_t;

endpackage

/* File: hdl/scs_flag.sv */
`timescale 1ns/10ps
module scs_flag (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);

  logic q_r;
  logic q_nxt;

  // Set wins so an event in the clearing cycle is not lost
  always_comb begin
    q_nxt = set | (q_r & ~clr);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

/* File: hdl/scs_resid.sv */
`timescale 1ns/10ps
module scs_resid import scs_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic        step,
  output logic      [15:0] resid
);

  logic [15:0] resid_r;
  logic [15:0] resid_nxt;

  // Two's complement plus one: -n + 1 = ~n + 2; each byte moved steps it up by one
  always_comb begin
    resid_nxt = resid_r;
    if (load) begin
      resid_nxt = 16'(~load_val + RESID_BIAS);
    end else if (step) begin
      resid_nxt = 16'(resid_r + RESID_INC);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      resid_r <= RST_WORD;
    end else begin
      resid_r <= resid_nxt;
    end
  end

  assign resid = resid_r;

endmodule

/* File: hdl/scs_channel.sv */
`timescale 1ns/10ps
// How it works
// - Incorrect length stops chaining unless suppress flag
// - Adapter busy ignores launch; abort, read still run
// - Unit operational set only when data moves
// - Modifier 01/10/11 reads unit, pointer, count words
// - Unit word: address high byte, raw status low
// - Device end plus modifier chains six ahead
// - Channel end shown only at chain end
// - Clean device end with chaining starts next
// - Unit check or exception stops chaining
// - Command pointer is descriptor address plus three
// - Count kept as complement plus one, reset-proof
// - Launch while busy dropped without any sign
// - Busy unit at launch: pending, cleared by 01+reset
// - Unrecognised address raises not operational
// - Four sixteen-bit status words, read individually
// - Modifier 00 reads channel status word
// - Bits 0, 2, 3 clear only with reset bit
module scs_channel import scs_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_func,
  input  wire logic [15:0] cmd_mod,
  input  wire logic        sel_done,
  input  wire logic        sel_recog,
  input  wire logic [7:0]  sel_status,
  input  wire logic        xfer_start,
  input  wire logic        cnt_step,
  input  wire logic        len_err,
  input  wire logic        parity_err,
  input  wire logic        unit_stat_valid,
  input  wire logic [7:0]  unit_stat,
  input  wire logic        desc_load,
  input  wire logic [15:0] desc_addr,
  input  wire logic [15:0] desc_count,
  input  wire logic        desc_chain,
  input  wire logic        desc_sli,
  input  wire logic        desc_pci,
  output logic      [15:0] acc_data_r,
  output logic             acc_valid_r,
  output logic             sel_req_r,
  output logic      [7:0]  sel_addr_r,
  output logic             fetch_req_r,
  output logic      [15:0] fetch_addr_r,
  output logic             irq_r
);

  scs_state_t  st_r;
  scs_state_t  st_nxt;
  logic [7:0]  us_r;
  logic [7:0]  us_nxt;
  logic [7:0]  ua_nxt;
  logic [15:0] daddr_r;
  logic [15:0] daddr_nxt;
  logic        chain_r;
  logic        chain_nxt;
  logic        sli_r;
  logic        sli_nxt;
  logic        inclen_r;
  logic        inclen_nxt;
  logic        uop_r;
  logic        uop_nxt;
  logic        sel_req_nxt;
  logic        fetch_req_nxt;
  logic [15:0] fetch_addr_nxt;
  logic [15:0] acc_data_nxt;
  logic        acc_valid_nxt;
  logic        irq_nxt;

  logic        is_read;
  logic        is_launch;
  logic        is_abort;
  logic        bad_fn;
  logic [1:0]  rd_sel;
  logic        rd_rst;
  logic        busy;
  logic        chain_ok;
  logic [15:0] next_desc;
  logic        set_notop;
  logic        set_usp;
  logic        clr_usp;
  logic        notop;
  logic        usp;
  logic        pci;
  logic        pchk;
  logic [15:0] resid;

  assign is_read   = cmd_valid && (cmd_func == FN_READ);
  assign is_launch = cmd_valid && (cmd_func == FN_LAUNCH);
  assign is_abort  = cmd_valid && (cmd_func == FN_ABORT);
  assign bad_fn    = cmd_valid && (cmd_func != FN_READ) && (cmd_func != FN_LAUNCH)
                     && (cmd_func != FN_ABORT) && (cmd_func != FN_CTRL);
  assign rd_sel    = cmd_mod[MOD_SEL_HI:MOD_SEL_LO];
  assign rd_rst    = cmd_mod[MOD_RST];
  assign busy      = (st_r != ST_IDLE);
  // Unit check, exception or unsuppressed incorrect length end the chain
  assign chain_ok  = chain_r && !unit_stat[US_UC] && !unit_stat[US_UE]
                     && !(inclen_r && !sli_r);
  assign next_desc = 16'(daddr_r + (unit_stat[US_SM] ? CHAIN_SKIP : CPTR_STEP));
  assign clr_usp   = is_read && rd_rst && (rd_sel == SEL_UNIT);

  scs_flag u_notop (.clk_sys(clk_sys), .nrst(nrst), .set(set_notop),
                    .clr(is_read && rd_rst), .q(notop));
  scs_flag u_usp   (.clk_sys(clk_sys), .nrst(nrst), .set(set_usp),
                    .clr(clr_usp), .q(usp));
  scs_flag u_pci   (.clk_sys(clk_sys), .nrst(nrst), .set(desc_load && desc_pci),
                    .clr(is_read && rd_rst), .q(pci));
  scs_flag u_pchk  (.clk_sys(clk_sys), .nrst(nrst), .set(bad_fn || parity_err),
                    .clr(is_read && rd_rst), .q(pchk));

  scs_resid u_resid (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .load     (desc_load),
    .load_val (desc_count),
    .step     (cnt_step),
    .resid    (resid)
  );

  // Selection, operation and chaining sequence
  always_comb begin
    st_nxt         = st_r;
    us_nxt         = us_r;
    ua_nxt         = sel_addr_r;
    uop_nxt        = uop_r;
    sel_req_nxt    = 1'b0;
    fetch_req_nxt  = 1'b0;
    fetch_addr_nxt = fetch_addr_r;
    set_notop      = 1'b0;
    set_usp        = 1'b0;
    case (st_r)
      ST_IDLE: begin
        // Launch is only looked at while idle, so a busy launch leaves no trace
        if (is_launch) begin
          ua_nxt      = cmd_mod[MOD_ADDR_HI:MOD_ADDR_LO];
          sel_req_nxt = 1'b1;
          uop_nxt     = 1'b0;
          st_nxt      = ST_SELECT;
        end
      end
      ST_SELECT: begin
        if (sel_done) begin
          if (!sel_recog) begin
            set_notop = 1'b1;
            st_nxt    = ST_IDLE;
          end else if (sel_status[US_BUSY] || (sel_status[US_UC] && !sel_status[US_CE])) begin
            us_nxt  = sel_status;
            set_usp = 1'b1;
            st_nxt  = ST_IDLE;
          end else if (sel_status[US_CE] && sel_status[US_DE]
                       && chain_r && !sel_status[US_UC] && !sel_status[US_UE]) begin
            // Immediate command inside a chain: move on, hide its channel end
            fetch_addr_nxt = 16'(daddr_r + (sel_status[US_SM] ? CHAIN_SKIP : CPTR_STEP));
            fetch_req_nxt  = 1'b1;
            st_nxt         = ST_FETCH;
          end else if (sel_status[US_CE]) begin
            us_nxt  = sel_status;
            set_usp = 1'b1;
            st_nxt  = ST_IDLE;
          end else begin
            st_nxt = ST_ACTIVE;
          end
        end
      end
      ST_ACTIVE: begin
        if (xfer_start) begin
          uop_nxt = 1'b1;
        end
        if (unit_stat_valid && unit_stat[US_DE]) begin
          uop_nxt = 1'b0;
          if (chain_ok) begin
            fetch_addr_nxt = next_desc;
            fetch_req_nxt  = 1'b1;
            st_nxt         = ST_FETCH;
          end else begin
            us_nxt  = unit_stat;
            set_usp = 1'b1;
            st_nxt  = ST_IDLE;
          end
        end
      end
      ST_FETCH: begin
        if (desc_load) begin
          sel_req_nxt = 1'b1;
          st_nxt      = ST_SELECT;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    // Abort is honoured in every state, busy or not
    if (is_abort) begin
      st_nxt        = ST_IDLE;
      uop_nxt       = 1'b0;
      sel_req_nxt   = 1'b0;
      fetch_req_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r         <= ST_IDLE;
      us_r         <= RST_BYTE;
      sel_addr_r   <= RST_BYTE;
      uop_r        <= 1'b0;
      sel_req_r    <= 1'b0;
      fetch_req_r  <= 1'b0;
      fetch_addr_r <= RST_WORD;
    end else begin
      st_r         <= st_nxt;
      us_r         <= us_nxt;
      sel_addr_r   <= ua_nxt;
      uop_r        <= uop_nxt;
      sel_req_r    <= sel_req_nxt;
      fetch_req_r  <= fetch_req_nxt;
      fetch_addr_r <= fetch_addr_nxt;
    end
  end

  // Active descriptor; incorrect length is per descriptor, set wins over reload
  always_comb begin
    daddr_nxt  = daddr_r;
    chain_nxt  = chain_r;
    sli_nxt    = sli_r;
    inclen_nxt = inclen_r;
    if (desc_load) begin
      daddr_nxt  = desc_addr;
      chain_nxt  = desc_chain;
      sli_nxt    = desc_sli;
      inclen_nxt = 1'b0;
    end
    if (len_err) begin
      inclen_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      daddr_r  <= RST_WORD;
      chain_r  <= 1'b0;
      sli_r    <= 1'b0;
      inclen_r <= 1'b0;
    end else begin
      daddr_r  <= daddr_nxt;
      chain_r  <= chain_nxt;
      sli_r    <= sli_nxt;
      inclen_r <= inclen_nxt;
    end
  end

  // Accumulator path; the count is never touched by the reset bit
  always_comb begin
    acc_data_nxt  = acc_data_r;
    acc_valid_nxt = is_read;
    irq_nxt       = notop | usp | pci | pchk;
    if (is_read) begin
      case (rd_sel)
        SEL_CHAN: begin
          acc_data_nxt             = RST_WORD;
          acc_data_nxt[POS_NOTOP]  = notop;
          acc_data_nxt[POS_USP]    = usp;
          acc_data_nxt[POS_PCI]    = pci;
          acc_data_nxt[POS_PCHK]   = pchk;
          acc_data_nxt[POS_INCLEN] = inclen_r;
          acc_data_nxt[POS_BUSY]   = busy;
          acc_data_nxt[POS_UOP]    = uop_r;
        end
        SEL_UNIT: begin
          acc_data_nxt = {sel_addr_r, us_r};
        end
        SEL_CPTR: begin
          acc_data_nxt = 16'(daddr_r + CPTR_STEP);
        end
        SEL_RESID: begin
          acc_data_nxt = resid;
        end
        default: begin
          acc_data_nxt = RST_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      acc_data_r  <= RST_WORD;
      acc_valid_r <= 1'b0;
      irq_r       <= 1'b0;
    end else begin
      acc_data_r  <= acc_data_nxt;
      acc_valid_r <= acc_valid_nxt;
      irq_r       <= irq_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  AST_LAUNCH_DROPPED: assert property (
    is_launch && busy && !is_abort && !(st_r == ST_FETCH && desc_load)
    |=> !sel_req_r && $stable(sel_addr_r))
    else $error("launch taken while busy");
  AST_BUSY_SHOWN: assert property (
    is_read && rd_sel == SEL_CHAN |=> acc_valid_r && acc_data_r[POS_BUSY] == $past(busy))
    else $error("busy bit misreported");
  AST_UNIT_WORD: assert property (
    is_read && rd_sel == SEL_UNIT |=> acc_data_r == {$past(sel_addr_r), $past(us_r)})
    else $error("unit word wrong");
  AST_CPTR_WORD: assert property (
    desc_load ##1 (is_read && rd_sel == SEL_CPTR && !desc_load)
    |=> acc_data_r == 16'($past(desc_addr, 2) + 16'h0003))
    else $error("pointer not plus three");
  AST_RESID_HELD: assert property (
    is_read && rd_rst && !desc_load && !cnt_step |=> $stable(resid))
    else $error("count moved by reset bit");
  AST_USP_HOLD: assert property (
    usp && !clr_usp |=> usp)
    else $error("pending cleared wrongly");
  AST_NOTOP_SET: assert property (
    st_r == ST_SELECT && sel_done && !sel_recog && !is_abort |=> notop ##1 irq_r)
    else $error("not operational missed");
  AST_SKIP_SIX: assert property (
    st_r == ST_ACTIVE && unit_stat_valid && unit_stat[US_DE] && unit_stat[US_SM]
    && chain_ok && !is_abort |=> fetch_req_r && fetch_addr_r == 16'($past(daddr_r) + 16'h0006))
    else $error("modifier skip wrong");
  AST_CHAIN_STOP: assert property (
    st_r == ST_ACTIVE && unit_stat_valid && unit_stat[US_DE]
    && (unit_stat[US_UC] || unit_stat[US_UE] || (inclen_r && !sli_r))
    |=> !fetch_req_r ##1 !fetch_req_r)
    else $error("chaining not suppressed");
  AST_UOP_CAUSE: assert property (
    $rose(uop_r) |-> $past(xfer_start) && $past(st_r) == ST_ACTIVE)
    else $error("unit operational without data");

  COV_CHAIN: cover property (fetch_req_r ##[1:20] sel_req_r);
  COV_BUSY_UNIT: cover property (set_usp && sel_status[US_BUSY] ##[1:20] clr_usp);
  COV_NOTOP: cover property (set_notop);
  COV_END: cover property (st_r == ST_ACTIVE ##1 st_r == ST_IDLE && usp);

endmodule

/* File: testbench/scs_unit_model.sv */
`timescale 1ns/10ps
module scs_unit_model (
  input  wire logic       clk_sys,
  input  wire logic       sel_req,
  input  wire logic       recog_cfg,
  input  wire logic [7:0] sel_st_cfg,
  input  wire logic [7:0] end_st_cfg,
  input  wire logic       len_cfg,
  input  wire logic [3:0] nbytes_cfg,
  output logic            sel_done,
  output logic            sel_recog,
  output logic [7:0]      sel_status,
  output logic            xfer_start,
  output logic            cnt_step,
  output logic            len_err,
  output logic            unit_stat_valid,
  output logic [7:0]      unit_stat
);
  initial begin
    {sel_done, sel_recog, xfer_start, cnt_step, len_err, unit_stat_valid} = 6'h00;
    sel_status = 8'hFF;
    unit_stat = 8'hFF;
    forever begin
      @(posedge clk_sys);
      if (sel_req === 1'b1) begin
        repeat (2) @(posedge clk_sys);
        sel_done <= 1'b1;
        sel_recog <= recog_cfg;
        sel_status <= sel_st_cfg;
        @(posedge clk_sys);
        // Released lines show the inverse so a stale byte cannot pass
        sel_done <= 1'b0;
        sel_recog <= ~recog_cfg;
        sel_status <= ~sel_st_cfg;
        if (recog_cfg && sel_st_cfg == 8'h00) begin
          xfer_start <= 1'b1;
          @(posedge clk_sys);
          xfer_start <= 1'b0;
          repeat (nbytes_cfg) begin
            repeat (3) @(posedge clk_sys);
            cnt_step <= 1'b1;
            @(posedge clk_sys);
            cnt_step <= 1'b0;
          end
          len_err <= len_cfg;
          @(posedge clk_sys);
          len_err <= 1'b0;
          unit_stat_valid <= 1'b1;
          unit_stat <= end_st_cfg;
          @(posedge clk_sys);
          unit_stat_valid <= 1'b0;
          unit_stat <= ~end_st_cfg;
        end
      end
    end
  end
endmodule

/* File: testbench/scs_channel_tb.sv */
`timescale 1ns/10ps
module scs_channel_tb import scs_pkg::*;;
  logic        clk_sys = 1'b0;
  logic        nrst, cmd_valid, sel_done, sel_recog, xfer_start, cnt_step, len_err;
  logic        parity_err, unit_stat_valid, desc_load, desc_chain, desc_sli, desc_pci;
  logic        acc_valid_r, sel_req_r, fetch_req_r, irq_r, recog_cfg, len_cfg;
  logic [2:0]  cmd_func;
  logic [3:0]  nbytes_cfg;
  logic [7:0]  sel_status, unit_stat, sel_addr_r, sel_st_cfg, end_st_cfg, a;
  logic [15:0] cmd_mod, desc_addr, desc_count, acc_data_r, fetch_addr_r, c;
  logic [15:0] rnd = 16'h0032;
  logic [15:0] eq[$];
  logic [15:0] fq[$];
  string       nq[$];
  int          error_cnt = 0;
  int          total_checks = 0;
  int          sel_cnt = 0;
  localparam logic [7:0]  SST [4] = '{8'h50, 8'h10, 8'h0C, 8'h00};
  localparam logic [15:0] CEX [4] = '{16'h4000, 16'h4000, 16'h4000, 16'h8000};
  localparam logic [7:0]  ENDS [6] = '{8'h0C, 8'h4C, 8'h0E, 8'h0D, 8'h0C, 8'h0C};
  localparam logic [15:0] OFS [6] = '{16'h0003, 16'h0006, 16'h0000, 16'h0000, 16'h0000,
                                      16'h0003};

  always #2.5 clk_sys = ~clk_sys;

  scs_channel scs_channel_i (.clk_sys, .nrst, .cmd_valid, .cmd_func, .cmd_mod, .sel_done,
    .sel_recog, .sel_status, .xfer_start, .cnt_step, .len_err, .parity_err, .unit_stat_valid,
    .unit_stat, .desc_load, .desc_addr, .desc_count, .desc_chain, .desc_sli, .desc_pci,
    .acc_data_r, .acc_valid_r, .sel_req_r, .sel_addr_r, .fetch_req_r, .fetch_addr_r, .irq_r);

  scs_unit_model scs_unit_model_i (.clk_sys, .sel_req(sel_req_r), .recog_cfg, .sel_st_cfg,
    .end_st_cfg, .len_cfg, .nbytes_cfg, .sel_done, .sel_recog, .sel_status, .xfer_start,
    .cnt_step, .len_err, .unit_stat_valid, .unit_stat);

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cmd(input logic [2:0] f, input logic [15:0] m);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_func <= f;
    cmd_mod <= m;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] s, input logic r, input logic [15:0] e, input string nm);
    eq.push_back(e);
    nq.push_back(nm);
    cmd(FN_READ, {13'h0000, s, r});
  endtask

  task automatic setm(input logic r, input logic [7:0] s, input logic [7:0] e, input logic l,
                      input logic [3:0] n);
    recog_cfg <= r;
    sel_st_cfg <= s;
    end_st_cfg <= e;
    len_cfg <= l;
    nbytes_cfg <= n;
  endtask

  task automatic load(input logic [15:0] ad, input logic [15:0] ct, input logic ch,
                      input logic sl, input logic pc);
    @(posedge clk_sys);
    desc_load <= 1'b1;
    desc_addr <= ad;
    desc_count <= ct;
    desc_chain <= ch;
    desc_sli <= sl;
    desc_pci <= pc;
    @(posedge clk_sys);
    desc_load <= 1'b0;
  endtask

  // Bounded wait: 0 data start, 1 ending status, 2 selection done
  task automatic wait_for(input int k);
    for (int i = 0; i < 300 && ((k == 0) ? xfer_start :
         ((k == 1) ? unit_stat_valid : sel_done)) !== 1'b1; i++)
      @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    if (acc_valid_r === 1'b1) begin
      if (eq.size() == 0)
        chk("acc_unexpected", 16'h0000, 16'hFFFF);
      else
        chk(nq.pop_front(), eq.pop_front(), acc_data_r);
    end
    if (fetch_req_r === 1'b1) begin
      if (fq.size() == 0)
        chk("fetch_unexpected", 16'h0000, 16'hFFFF);
      else
        chk("fetch_addr", fq.pop_front(), fetch_addr_r);
    end
    if (sel_req_r === 1'b1)
      sel_cnt++;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end

  initial begin
    {nrst, cmd_valid, parity_err, desc_load, desc_chain, desc_sli, desc_pci} = 7'h00;
    {cmd_func, cmd_mod, desc_addr, desc_count} = 51'h0;
    {recog_cfg, len_cfg, sel_st_cfg, end_st_cfg, nbytes_cfg} = 22'h0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(SEL_CHAN, 1'b0, 16'h0000, "chan_reset");
    load(16'h0300, 16'h0001, 1'b0, 1'b0, 1'b1);
    cmd(3'h0, 16'h0000);
    rd(SEL_CHAN, 1'b1, 16'h3000, "chan_pchk_pci");
    rd(SEL_CHAN, 1'b0, 16'h0000, "chan_pchk_clear");
    parity_err <= 1'b1;
    @(posedge clk_sys);
    parity_err <= 1'b0;
    rd(SEL_CHAN, 1'b1, 16'h1000, "chan_parity");
    $display("test flags done");
    a = rnd[15:8];
    c = {8'h00, rnd[7:0]} + 16'h0010;
    rnd = lfsr(rnd);
    setm(1'b1, 8'h00, 8'h0C, 1'b0, 4'h5);
    load(16'h0100, c, 1'b0, 1'b0, 1'b0);
    cmd(FN_LAUNCH, {a, 8'h00});
    wait_for(0);
    rd(SEL_CHAN, 1'b0, 16'h0180, "chan_active");
    cmd(FN_LAUNCH, {a, 8'h00});
    wait_for(1);
    chk("sel_req_count", 16'h0001, sel_cnt[15:0]);
    #1 chk("irq_set", 16'h0001, {15'h0000, irq_r});
    rd(SEL_CHAN, 1'b0, 16'h4000, "chan_done");
    rd(SEL_RESID, 1'b1, ~c + 16'h0007, "resid");
    rd(SEL_RESID, 1'b0, ~c + 16'h0007, "resid_kept");
    rd(SEL_CPTR, 1'b0, 16'h0103, "cptr");
    rd(SEL_CHAN, 1'b1, 16'h4000, "chan_usp_kept");
    rd(SEL_UNIT, 1'b1, {a, 8'h0C}, "unit_word");
    rd(SEL_CHAN, 1'b0, 16'h0000, "chan_cleared");
    repeat (3) @(posedge clk_sys);
    #1 chk("irq_clear", 16'h0000, {15'h0000, irq_r});
    $display("test transfer done");
    for (int k = 0; k < 4; k++) begin
      setm(k != 3, SST[k], 8'h0C, 1'b0, 4'h1);
      a = rnd[7:0];
      rnd = lfsr(rnd);
      cmd(FN_LAUNCH, {a, 8'h00});
      wait_for(2);
      rd(SEL_CHAN, 1'b1, CEX[k], "chan_select");
      if (k != 3)
        rd(SEL_UNIT, 1'b1, {a, SST[k]}, "unit_select");
      rd(SEL_CHAN, 1'b0, 16'h0000, "chan_select_clear");
    end
    $display("test selection done");
    setm(1'b1, 8'h00, 8'h0C, 1'b0, 4'h3);
    cmd(FN_LAUNCH, {a, 8'h00});
    wait_for(0);
    cmd(FN_ABORT, 16'h0000);
    cmd(FN_CTRL, 16'h0000);
    rd(SEL_CHAN, 1'b0, 16'h0000, "chan_abort");
    wait_for(1);
    rd(SEL_CHAN, 1'b0, 16'h0000, "chan_abort_idle");
    $display("test abort done");
    for (int k = 0; k < 6; k++) begin
      setm(1'b1, 8'h00, ENDS[k], k >= 4, 4'h2);
      a = rnd[7:0];
      rnd = lfsr(rnd);
      if (OFS[k] != 16'h0000)
        fq.push_back(16'h0200 + OFS[k]);
      load(16'h0200, 16'h0002, 1'b1, k == 5, 1'b0);
      cmd(FN_LAUNCH, {a, 8'h00});
      wait_for(1);
      chk("fetch_pending", 16'h0000, 16'(fq.size()));
      if (OFS[k] != 16'h0000) begin
        setm(1'b1, 8'h00, 8'h0C, 1'b0, 4'h1);
        load(16'h0200 + OFS[k], 16'h0001, 1'b0, 1'b0, 1'b0);
        wait_for(1);
      end
      rd(SEL_CPTR, 1'b0, 16'h0203 + OFS[k], "cptr_chain");
      rd(SEL_UNIT, 1'b1, {a, ((OFS[k] != 16'h0000) ? 8'h0C : ENDS[k])}, "unit_chain");
    end
    $display("test chaining done");
    repeat (4) @(posedge clk_sys);
    chk("reads_pending", 16'h0000, 16'(eq.size()));
    stop_test();
  end
endmodule
